//--- core/sdram_cmd_pkg.sv
/*
  Constants for the SDRAM command interface: command codes, mode field
  positions, burst length codes, geometry and power states.
  Assumes a 100 MHz core clock and that the controller keeps its own timing.
*/
package sdram_cmd_pkg;
  // Strobe code {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_WRITE     = 4'h4;
  localparam logic [3:0] CMD_READ      = 4'h5;
  localparam logic [3:0] CMD_MODE_SET  = 4'h0;
  localparam logic [3:0] CMD_REFRESH   = 4'h1;
  localparam logic [3:0] CMD_IDLE      = 4'h7;
  localparam logic [3:0] CMD_STOP      = 4'h6;
  // Mode register field positions
  localparam int MODE_BL_LSB   = 0;
  localparam int MODE_BT_BIT   = 3;
  localparam int MODE_CL_LSB   = 4;
  // Burst length codes
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  // Geometry
  localparam int BANKS         = 4;
  localparam int ROW_BITS      = 12;
  localparam int COL_BITS      = 9;
  localparam int PRECHARGE_BIT = 10;
  localparam int FULL_PAGE_LEN = 512;
  // Reset values
  localparam logic [11:0] MODE_RESET = 12'h000;
  // Device states
  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_SUSPEND = 2'b01,
    ST_PWRDOWN = 2'b11
  } power_state_t;
endpackage

//--- core/sdram_burst_addr.sv
/*
  Burst column generator: next column for sequential or interleave order.
  Assumes the caller supplies the start column and beat index.
*/
`timescale 1ns/1ps
module sdram_burst_addr
  import sdram_cmd_pkg::*;
#(
  parameter int COLW = COL_BITS
) (
  input  wire logic [COLW-1:0] start_in,      // Burst start column
  input  wire logic [COLW-1:0] beat_in,       // Beat number in burst
  input  wire logic [2:0]      len_code_in,   // Burst length code
  input  wire logic            interleave_in, // Interleave order
  output logic      [COLW-1:0] col_out        // Column of this beat
);
  initial begin
    if (COLW < 3) $error("COLW too small");
  end
  // Wrap mask: low bits that change inside the burst
  wire [COLW-1:0] wrap_mask =
    (len_code_in == BL_2) ? COLW'(1) :
    (len_code_in == BL_4) ? COLW'(3) :
    (len_code_in == BL_8) ? COLW'(7) :
    (len_code_in == BL_PAGE) ? {COLW{1'b1}} : '0;
  wire [COLW-1:0] seq_col  = start_in + beat_in;  // No carry past mask
  wire [COLW-1:0] intl_col = start_in ^ beat_in;
  wire [COLW-1:0] moved    = interleave_in ? intl_col : seq_col;
  // Combine moving low bits with fixed high bits
  assign col_out = (moved & wrap_mask) | (start_in & ~wrap_mask);
endmodule

//--- core/sdram_command_interface.sv
/*
  SDRAM command interface: decodes strobes, holds mode and bank state, runs
  read and write bursts over a per-bank row array model.
  Assumes the controller obeys initialization, spacing and refresh timing.
*/
// Notes on behaviour
// RULE_01 - Commands decoded only at rising clock edge
// RULE_02 - Previous clock-enable sample high qualifies commands
// RULE_03 - Read: cs, cas low; ras, we high
// RULE_04 - Write: cs, cas, we low; ras high
// RULE_05 - Mode set only when idle, enable high
// RULE_06 - Controller waits mode-set recovery after setting
// RULE_07 - Controller waits 200 us, then precharge, mode
// RULE_08 - Controller issues eight refresh cycles at init
// RULE_09 - Mode register undefined until programmed
// RULE_10 - Activate before access, wait activate delay
// RULE_11 - Precharge before reactivating; respect row cycle
// RULE_12 - Activates to different banks spaced apart
// RULE_13 - Bank active no longer than hold limit
// RULE_14 - New row needs precharge then activate
// RULE_15 - Accept read or write every cycle
// RULE_16 - Burst type and length from mode register
// RULE_17 - Write data from command cycle onward
// RULE_18 - Access legal only to an active bank
// RULE_19 - Read interrupting read restarts full burst
// RULE_20 - Controller masks bytes on read-to-write turn
// RULE_21 - Burst stop only during full page bursts
// RULE_22 - Clock enable low in burst means suspend
// RULE_23 - Flag bit plus bank select chooses precharge
// RULE_24 - Flag bit on access selects auto-precharge; code ignores it in full page and never closes the bank at burst length 1
// RULE_25 - Chip select high is deselect, burst continues
`timescale 1ns/1ps
module sdram_command_interface
  import sdram_cmd_pkg::*;
#(
  parameter int DW       = 8,   // Data width
  parameter int MEM_COLS = 64   // Modelled columns per bank, power of two
) (
  input  wire logic                clock_in,
  input  wire logic                rst_in,        // Simulation-only init
  input  wire logic                cke_in,        // Clock enable
  input  wire logic                cs_n_in,
  input  wire logic                ras_n_in,
  input  wire logic                cas_n_in,
  input  wire logic                we_n_in,
  input  wire logic [1:0]          bank_select_in,
  input  wire logic [ROW_BITS-1:0] addr_in,
  input  wire logic                dqm_in,        // Byte mask
  input  wire logic [DW-1:0]       dq_in,
  output logic      [DW-1:0]       dq_out,
  output logic                     dq_oe_out,     // High while driving
  output logic                     mode_valid_out, // Mode programmed
  output logic [BANKS-1:0]         bank_active_out,
  output logic                     suspend_out    // Clock suspend state
);
  localparam int MCW = $clog2(MEM_COLS);
  initial begin
    if (DW < 1 || MEM_COLS < 8 || (MEM_COLS & (MEM_COLS - 1)) != 0)
      $error("Bad parameters");
  end

  // Storage per bank, columns folded to the modelled depth
  logic [DW-1:0] mem_q [BANKS*MEM_COLS];

  logic                  cke_prev_q;    // Clock enable one edge earlier
  logic [11:0]           mode_q;        // Mode register
  logic                  mode_valid_q;
  logic [BANKS-1:0]      active_q;
  logic [BANKS-1:0]      autopre_q;     // Close at burst end
  power_state_t          pstate_q;
  power_state_t          pstate_d;      // Next power state
  logic                  suspend_q;     // Registered suspend flag for the pin
  // Burst engine
  logic                  burst_q;       // Burst running
  logic                  burst_wr_q;
  logic [1:0]            burst_bank_q;
  logic [COL_BITS-1:0]   burst_start_q;
  logic [COL_BITS-1:0]   beat_q;
  // Read data pipeline, indexed by latency
  logic [DW-1:0]         rd_pipe_q [4];
  logic [3:0]            rd_vld_q;
  logic [DW-1:0]         dq_q;
  logic                  oe_q;

  // Command decode, qualified by the earlier enable sample
  wire       cmd_ok   = cke_prev_q & ~cs_n_in;           // see RULE_02, see RULE_25
  wire [3:0] cmd_code = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
  wire       is_act   = cmd_ok & (cmd_code == CMD_ACTIVATE);
  wire       is_pre   = cmd_ok & (cmd_code == CMD_PRECHARGE);
  wire       is_rd    = cmd_ok & (cmd_code == CMD_READ);   // see RULE_03
  wire       is_wr    = cmd_ok & (cmd_code == CMD_WRITE);  // see RULE_04
  wire       is_mrs   = cmd_ok & (cmd_code == CMD_MODE_SET);
  wire       is_stop  = cmd_ok & (cmd_code == CMD_STOP);
  // Access only to an active bank; others dropped
  wire       bank_ok  = active_q[bank_select_in];          // see RULE_18
  wire       acc_go   = (is_rd | is_wr) & bank_ok & mode_valid_q; // see RULE_09
  wire       pre_all  = addr_in[PRECHARGE_BIT];             // see RULE_23
  // Mode fields
  wire [2:0] len_code = mode_q[MODE_BL_LSB +: 3];           // see RULE_16
  wire       intl     = mode_q[MODE_BT_BIT];
  wire [1:0] cas_lat  = mode_q[MODE_CL_LSB +: 2];
  wire       full_pg  = (len_code == BL_PAGE);
  // Burst length in beats
  wire [COL_BITS:0] blen =
    (len_code == BL_1) ? (COL_BITS+1)'(1) :
    (len_code == BL_2) ? (COL_BITS+1)'(2) :
    (len_code == BL_4) ? (COL_BITS+1)'(4) :
    (len_code == BL_8) ? (COL_BITS+1)'(8) :
    (COL_BITS+1)'(FULL_PAGE_LEN);
  wire last_beat = ({1'b0, beat_q} + (COL_BITS+1)'(1)) >= blen;
  // A suspended cycle freezes the burst
  wire hold      = (pstate_q == ST_SUSPEND) | ~cke_prev_q;  // see RULE_22

  // Column for the running beat, or beat 0 of a new access
  wire [COL_BITS-1:0] col_now;
  wire [COL_BITS-1:0] start_sel = acc_go ? addr_in[COL_BITS-1:0] : burst_start_q;
  wire [COL_BITS-1:0] beat_sel  = acc_go ? '0 : beat_q;
  sdram_burst_addr #(.COLW(COL_BITS)) u_addr (
    .start_in      (start_sel),
    .beat_in       (beat_sel),
    .len_code_in   (len_code),
    .interleave_in (intl),
    .col_out       (col_now)
  );
  wire [1:0]  cur_bank = acc_go ? bank_select_in : burst_bank_q;
  wire        cur_wr   = acc_go ? is_wr : burst_wr_q;
  wire        beat_on  = acc_go | (burst_q & ~hold);
  wire [$clog2(BANKS*MEM_COLS)-1:0] mem_idx = {cur_bank, col_now[MCW-1:0]};
  // Write beat stored unless masked; data after burst end ignored
  wire do_write = beat_on & cur_wr & ~dqm_in;               // see RULE_17
  wire do_read  = beat_on & ~cur_wr;
  // Burst ended without a new access closes its auto-precharge bank
  wire burst_done = burst_q & ~hold & last_beat & ~acc_go;

  // Mode register and clock enable history
  always_ff @(posedge clock_in) begin                       // see RULE_01
    cke_prev_q <= rst_in ? 1'b0 : cke_in;
    if (rst_in) begin
      mode_q       <= MODE_RESET;
      mode_valid_q <= 1'b0;
    end else if (is_mrs && active_q == '0) begin
      mode_q       <= addr_in;
      mode_valid_q <= 1'b1;
    end
  end

  // Bank open and close
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      active_q  <= '0;
      autopre_q <= '0;
    end else begin
      if (is_act)
        active_q[bank_select_in] <= 1'b1;
      if (is_pre && pre_all) begin                          // see RULE_23
        active_q  <= '0;
        autopre_q <= '0;
      end else if (is_pre) begin
        active_q[bank_select_in]  <= 1'b0;
        autopre_q[bank_select_in] <= 1'b0;
      end
      if (acc_go && addr_in[PRECHARGE_BIT] && !full_pg)   // see RULE_24
        autopre_q[bank_select_in] <= 1'b1;
      if (burst_done && autopre_q[burst_bank_q]) begin
        active_q[burst_bank_q]  <= 1'b0;
        autopre_q[burst_bank_q] <= 1'b0;
      end
    end
  end

  // Burst engine: a new access restarts a full burst
  always_ff @(posedge clock_in) begin                       // see RULE_15
    if (rst_in) begin
      burst_q       <= 1'b0;
      burst_wr_q    <= 1'b0;
      burst_bank_q  <= '0;
      burst_start_q <= '0;
      beat_q        <= '0;
    end else if (acc_go) begin                              // see RULE_19
      burst_q       <= (blen != (COL_BITS+1)'(1));
      burst_wr_q    <= is_wr;
      burst_bank_q  <= bank_select_in;
      burst_start_q <= addr_in[COL_BITS-1:0];
      beat_q        <= COL_BITS'(1);
    end else if (is_stop && full_pg) begin                  // see RULE_21
      burst_q <= 1'b0;
    end else if (burst_q && !hold) begin                    // see RULE_25
      burst_q <= ~last_beat & ~(full_pg & 1'b0);
      beat_q  <= beat_q + COL_BITS'(1);
    end
  end

  // Array write port
  always_ff @(posedge clock_in) begin
    if (do_write)
      mem_q[mem_idx] <= dq_in;
  end

  // Power state: enable low in a burst gives suspend, else power-down
  assign pstate_d = (cke_prev_q && !cke_in) ?
                    ((burst_q | acc_go) ? ST_SUSPEND : ST_PWRDOWN) :
                    (cke_in ? ST_RUN : pstate_q);
  // Suspend flag registered from the next state so the pin comes from a flop
  always_ff @(posedge clock_in) begin                       // see RULE_22
    if (rst_in) begin
      pstate_q  <= ST_RUN;
      suspend_q <= 1'b0;
    end else begin
      pstate_q  <= pstate_d;
      suspend_q <= (pstate_d == ST_SUSPEND);
    end
  end

  // Read pipeline; old data keeps flowing until new latency elapses
  always_ff @(posedge clock_in) begin                       // see RULE_19
    if (rst_in) begin
      rd_vld_q <= '0;
      for (int i = 0; i < 4; i++)
        rd_pipe_q[i] <= '0;
    end else if (!hold || acc_go) begin
      rd_pipe_q[0] <= mem_q[mem_idx];
      rd_vld_q[0]  <= do_read;
      for (int i = 1; i < 4; i++) begin
        rd_pipe_q[i] <= rd_pipe_q[i-1];
        rd_vld_q[i]  <= rd_vld_q[i-1];
      end
    end
  end

  // Output stage: data at latency 3 if programmed, else 2, masked by byte mask
  wire [1:0] tap = (cas_lat == 2'h3) ? 2'h1 : 2'h0;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      dq_q <= '0;
      oe_q <= 1'b0;
    end else begin
      dq_q <= rd_pipe_q[tap];
      oe_q <= rd_vld_q[tap] & ~dqm_in;
    end
  end

  assign dq_out          = dq_q;
  assign dq_oe_out       = oe_q;
  assign mode_valid_out  = mode_valid_q;
  assign bank_active_out = active_q;
  assign suspend_out     = suspend_q;
endmodule

//--- test/sdram_command_interface_sva.sv
/* Port checker for the SDRAM command interface.
   Assumes a bind onto the top module; one clock, synchronous reset. */
`timescale 1ns/1ps
module sdram_command_interface_sva
  import sdram_cmd_pkg::*;
(
  input wire logic                clock_in,
  input wire logic                rst_in,
  input wire logic                cke_in,
  input wire logic                cs_n_in,
  input wire logic                ras_n_in,
  input wire logic                cas_n_in,
  input wire logic                we_n_in,
  input wire logic [1:0]          bank_select_in,
  input wire logic [ROW_BITS-1:0] addr_in,
  input wire logic                dqm_in,
  input wire logic                dq_oe_out,
  input wire logic                mode_valid_out,
  input wire logic [BANKS-1:0]    bank_active_out,
  input wire logic                suspend_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic       cke_q;  // Enable seen at the previous edge
  logic [1:0] cl_q;   // Latency from the last mode set
  wire [3:0] cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
  wire       go  = cke_q && !cs_n_in;  // Qualified command edge
  wire       ms  = go && cmd == CMD_MODE_SET && bank_active_out == '0;
  wire       rd  = go && cmd == CMD_READ && mode_valid_out && bank_active_out[bank_select_in];
  // Mirrors the enable pipe; starts low like the design's
  always_ff @(posedge clock_in) begin
    cke_q <= rst_in ? 1'b0 : cke_in;
    if (ms) cl_q <= addr_in[5:4];
  end
  sequence s_rd_cl2; rd && cl_q == 2'd2 && !dqm_in; endsequence
  sequence s_rd_cl3; rd && cl_q == 2'd3 && !dqm_in; endsequence
  property p_mode; ms |=> mode_valid_out; endproperty
  a_mode: assert property (p_mode) else $error("mode set not taken");
  property p_no_out; !mode_valid_out |-> !dq_oe_out; endproperty
  a_no_out: assert property (p_no_out) else $error("data before mode set");
  property p_lat2; s_rd_cl2 |-> ##2 (dq_oe_out || $past(dqm_in)); endproperty
  a_lat2: assert property (p_lat2) else $error("latency two missed");
  property p_lat3; s_rd_cl3 |-> ##3 (dq_oe_out || $past(dqm_in)); endproperty
  a_lat3: assert property (p_lat3) else $error("latency three missed");
  property p_act; go && cmd == CMD_ACTIVATE |=> bank_active_out[$past(bank_select_in)];
  endproperty
  a_act: assert property (p_act) else $error("bank not opened");
  property p_pre_one; go && cmd == CMD_PRECHARGE && !addr_in[PRECHARGE_BIT]
    |=> !bank_active_out[$past(bank_select_in)]; endproperty
  a_pre_one: assert property (p_pre_one) else $error("bank not closed");
  property p_pre_all; go && cmd == CMD_PRECHARGE && addr_in[PRECHARGE_BIT]
    |=> bank_active_out == '0; endproperty
  a_pre_all: assert property (p_pre_all) else $error("banks not closed");
  property p_desel; cs_n_in && bank_active_out == '0 |=> bank_active_out == '0; endproperty
  a_desel: assert property (p_desel) else $error("deselect opened a bank");
  property p_gate; !cke_q && bank_active_out == '0
    |=> bank_active_out == '0 && $stable(mode_valid_out); endproperty
  a_gate: assert property (p_gate) else $error("unqualified command taken");
  property p_pdown; !cke_in && bank_active_out == '0 && !dq_oe_out |=> !suspend_out;
  endproperty
  a_pdown: assert property (p_pdown) else $error("suspend while idle");
endmodule

//--- test/sdram_ctrl_model.sv
/* Controller model driving commands, mask, enable and write data.
   Assumes one bench process calls its tasks after reset. */
`timescale 1ns/1ps
module sdram_ctrl_model
  import sdram_cmd_pkg::*;
#(
  parameter int INIT_CYC = 20000, // Power-up pause, 200 us
  parameter int GAP      = 2      // Spacing after activate, refresh, mode set
) (
  input  wire logic        clock_in,
  output logic             cke_out,
  output logic [3:0]       cmd_out,  // {cs_n, ras_n, cas_n, we_n}
  output logic [1:0]       bank_out,
  output logic [11:0]      addr_out,
  output logic             dqm_out,
  output logic [7:0]       dq_out
);
  // Power-up levels: enable and mask high, bus deselected
  initial begin
    cke_out  = 1'b1;
    cmd_out  = 4'hF;
    bank_out = 2'h0;
    addr_out = 12'h000;
    dqm_out  = 1'b1;
    dq_out   = 8'h00;
  end
  // Deselect; released data flips so it never looks held
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clock_in);
      cmd_out <= 4'hF;
      dq_out  <= ~dq_out;
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                     input logic [7:0] d, input bit last);
    @(posedge clock_in);
    cmd_out  <= c;
    bank_out <= b;
    addr_out <= a;
    dq_out   <= d;
    if (last) idle(1);
  endtask
  // Mode set only with every bank closed
  task automatic set_mode(input logic [11:0] m);
    cmd(CMD_PRECHARGE, 2'h0, 12'h400, 8'h00, 1'b1);
    idle(GAP);
    cmd(CMD_MODE_SET, 2'h0, m, 8'h00, 1'b1);
    idle(GAP);
  endtask
  task automatic power_up(input logic [11:0] m);
    idle(INIT_CYC);
    set_mode(m);
    repeat (8) begin
      cmd(CMD_REFRESH, 2'h0, 12'h000, 8'h00, 1'b1);
      idle(GAP);
    end
    dqm_out <= 1'b0;
  endtask
  task automatic act(input logic [1:0] b, input logic [11:0] row);
    cmd(CMD_ACTIVATE, b, row, 8'h00, 1'b1);
    idle(GAP);
  endtask
  // Masked first beat carries inverted data, so a stored mask shows up
  task automatic wr(input logic [8:0] col, input logic [7:0] base, input bit m);
    cmd(CMD_WRITE, 2'h0, {3'h0, col}, m ? ~base : base, 1'b0);
    dqm_out <= m;
    for (int i = 1; i < 4; i++) begin
      @(posedge clock_in);
      cmd_out <= 4'hF;
      dq_out  <= base + 8'(i);
      dqm_out <= 1'b0;
    end
    idle(1);
  endtask
  task automatic stall(input int n);
    @(posedge clock_in);
    cke_out <= 1'b0;
    repeat (n) @(posedge clock_in);
    cke_out <= 1'b1;
  endtask
endmodule

//--- test/test_sdram_command_interface.sv
/* Bench: model controller drives the interface; read data and flags are
   compared with values worked out here. Assumes checker and model compile first. */
`timescale 1ns/1ps
module test_sdram_command_interface;
  import sdram_cmd_pkg::*;
  logic        clock_in = 1'b0;
  logic        rst_in   = 1'b1;
  logic        cke;
  logic [3:0]  cmd;
  logic [1:0]  bank;
  logic [11:0] addr;
  logic        dqm;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        oe;
  logic        mode_valid;
  logic [3:0]  active;
  logic        suspend;
  int          failures = 0;
  int          n_tests  = 0;
  int          cycles   = 0;
  always #5 clock_in = ~clock_in;
  sdram_ctrl_model i_sdram_ctrl_model (.clock_in(clock_in), .cke_out(cke), .cmd_out(cmd),
    .bank_out(bank), .addr_out(addr), .dqm_out(dqm), .dq_out(wdata));
  sdram_command_interface #(.DW(8), .MEM_COLS(64)) i_sdram_command_interface (
    .clock_in(clock_in), .rst_in(rst_in), .cke_in(cke), .cs_n_in(cmd[3]),
    .ras_n_in(cmd[2]), .cas_n_in(cmd[1]), .we_n_in(cmd[0]), .bank_select_in(bank),
    .addr_in(addr), .dqm_in(dqm), .dq_in(wdata), .dq_out(rdata), .dq_oe_out(oe),
    .mode_valid_out(mode_valid), .bank_active_out(active), .suspend_out(suspend));
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Four beats from now; column 8 onward holds A0 upward
  task automatic beats(input logic [8:0] s, input bit il);
    logic [8:0] c;
    for (int j = 0; j < 4; j++) begin
      c = il ? (s ^ 9'(j)) : {s[8:2], s[1:0] + 2'(j)};
      chk({7'h00, oe}, 8'h01);
      chk(rdata, c[7:0] + 8'h98);
      @(posedge clock_in);
      #1;
    end
  endtask
  task automatic rd(input logic [8:0] s, input int cl, input bit il);
    i_sdram_ctrl_model.cmd(CMD_READ, 2'h0, {3'h0, s}, 8'h00, 1'b1);
    repeat (cl - 1) @(posedge clock_in);
    #1 beats(s, il);
  endtask
  // Read cut by a masked write: no read data while the write owns the bus
  task automatic t_turn();
    i_sdram_ctrl_model.cmd(CMD_READ, 2'h0, 12'h008, 8'h00, 1'b0);
    fork
      i_sdram_ctrl_model.wr(9'h008, 8'hA0, 1'b1);
      begin
        repeat (2) @(posedge clock_in);
        repeat (3) begin
          #1 chk({7'h00, oe}, 8'h00);
          @(posedge clock_in);
        end
      end
    join
  endtask
  // Enable low with all banks closed is power-down, not suspend
  task automatic t_pdown();
    fork
      i_sdram_ctrl_model.stall(3);
      begin
        repeat (3) @(posedge clock_in);
        #1 chk({7'h00, suspend}, 8'h00);
      end
    join
  endtask
  // Full-page read ended by burst stop; a running page would keep driving
  task automatic t_stop();
    i_sdram_ctrl_model.cmd(CMD_READ, 2'h0, 12'h008, 8'h00, 1'b0);
    i_sdram_ctrl_model.cmd(CMD_STOP, 2'h0, 12'h000, 8'h00, 1'b1);
    #1 chk(rdata, 8'hA0);
    repeat (2) @(posedge clock_in);
    repeat (4) begin
      #1 chk({7'h00, oe}, 8'h00);
      @(posedge clock_in);
    end
  endtask
  task automatic t_closed();
    i_sdram_ctrl_model.cmd(CMD_READ, 2'h1, 12'h008, 8'h00, 1'b1);
    repeat (6) begin
      @(posedge clock_in);
      #1 chk({7'h00, oe}, 8'h00);
    end
  endtask
  task automatic t_back_to_back();
    i_sdram_ctrl_model.cmd(CMD_READ, 2'h0, 12'h008, 8'h00, 1'b0);
    i_sdram_ctrl_model.cmd(CMD_READ, 2'h0, 12'h009, 8'h00, 1'b1);
    #1 chk(rdata, 8'hA0);
    @(posedge clock_in);
    #1 beats(9'h009, 1'b0);
  endtask
  task automatic t_suspend();
    i_sdram_ctrl_model.cmd(CMD_READ, 2'h0, 12'h008, 8'h00, 1'b1);
    fork
      i_sdram_ctrl_model.stall(4);
      begin
        repeat (4) @(posedge clock_in);
        #1 chk({7'h00, suspend}, 8'h01);
      end
    join
    i_sdram_ctrl_model.idle(12);
    #1 chk({7'h00, suspend}, 8'h00);
  endtask
  // Bound on the whole run
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    i_sdram_ctrl_model.power_up(12'h022);
    chk({7'h00, mode_valid}, 8'h01);
    i_sdram_ctrl_model.act(2'h0, 12'h005);
    chk({4'h0, active}, 8'h01);
    t_closed();
    i_sdram_ctrl_model.wr(9'h008, 8'hA0, 1'b0);
    t_turn();
    rd(9'h008, 2, 1'b0);
    rd(9'h00A, 2, 1'b0);
    t_back_to_back();
    t_suspend();
    i_sdram_ctrl_model.set_mode(12'h027);
    t_pdown();
    i_sdram_ctrl_model.act(2'h0, 12'h005);
    t_stop();
    i_sdram_ctrl_model.set_mode(12'h03A);
    chk({4'h0, active}, 8'h00);
    i_sdram_ctrl_model.act(2'h0, 12'h005);
    rd(9'h009, 3, 1'b1);
    summarize();
  end
endmodule
bind sdram_command_interface sdram_command_interface_sva i_sdram_command_interface_sva (
  .clock_in, .rst_in, .cke_in, .cs_n_in, .ras_n_in, .cas_n_in, .we_n_in, .bank_select_in,
  .addr_in, .dqm_in, .dq_oe_out, .mode_valid_out, .bank_active_out, .suspend_out);
